// >>> gx_pkg.sv
/*
  Shared constants and types for the serial I/O port expander slave.
  Assumes it is compiled before every other file of the block.
*/
`default_nettype none

package gx_pkg;

  // ----------------------------------------------------------------
  // Port geometry and addressing
  // ----------------------------------------------------------------
  localparam int unsigned PORT_W      = 8;
  localparam logic [3:0]  ADDR_PREFIX = 4'h4;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [2:0]  FIRST_BIT   = 3'h0;

  // ----------------------------------------------------------------
  // Command bytes selecting a register
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_INPUT    = 8'h00;
  localparam logic [7:0] CMD_OUTPUT   = 8'h01;
  localparam logic [7:0] CMD_POLARITY = 8'h02;
  localparam logic [7:0] CMD_CONFIG   = 8'h03;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INPUT    = 8'hff;
  localparam logic [7:0] RST_OUTPUT   = 8'hff;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_CONFIG   = 8'hff;
  localparam logic [7:0] RST_PTR      = 8'h00;
  localparam logic [7:0] RST_STRAP    = 8'h00;

  // ----------------------------------------------------------------
  // Link engine states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE      = 8'h01,
    ST_ADDR      = 8'h02,
    ST_ADDR_ACK  = 8'h04,
    ST_WR        = 8'h08,
    ST_WR_ACK    = 8'h10,
    ST_RD        = 8'h20,
    ST_RD_ACK    = 8'h40,
    ST_WAIT_STOP = 8'h80
  } gx_state_t;

  // Register write carried from the link to the system domain
  typedef struct packed {
    logic [1:0] idx;
    logic [7:0] data;
  } gx_wr_t;

  // Writable register set
  typedef struct packed {
    logic [7:0] outp;
    logic [7:0] pol;
    logic [7:0] cfg;
  } gx_regs_t;

  localparam gx_regs_t RST_REGS = '{outp: RST_OUTPUT, pol: RST_POLARITY, cfg: RST_CONFIG};
  localparam gx_wr_t   RST_WR   = '{idx: 2'h0, data: 8'h00};

endpackage

`default_nettype wire

// >>> gx_regfile.sv
/*
  Output, polarity and direction registers of the port expander.
  Assumes writes arrive already in the system clock domain, one per pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module gx_regfile
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_sys_rst,
  input  wire logic            i_ce,
  input  wire logic            i_wr_en,
  input  wire gx_pkg::gx_wr_t  i_wr,
  output var  gx_pkg::gx_regs_t o_regs
);
  import gx_pkg::*;

  gx_regs_t next_regs;

  // ----------------------------------------------------------------
  // Write decode; the input port index is read only and ignored
  // ----------------------------------------------------------------
  always_comb
  begin
    next_regs = o_regs;
    if (i_wr_en)
    begin
      case (i_wr.idx)
        CMD_OUTPUT[1:0]:   next_regs.outp = i_wr.data;
        CMD_POLARITY[1:0]: next_regs.pol  = i_wr.data;
        CMD_CONFIG[1:0]:   next_regs.cfg  = i_wr.data;
        default:           next_regs      = o_regs;
      endcase
    end
  end

  // Register stage, frozen while the clock enable is low
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_regs <= RST_REGS;
    else if (i_ce)
      o_regs <= next_regs;
  end

endmodule

`default_nettype wire

// >>> gx_i2c_expander.sv
/*
  Serial slave front end and port logic of an eight-bit I/O expander.
  Assumes a bus master makes the serial clock; that clock is the link
  domain and may stand still between frames. Pins are three signals.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Start is data fall during clock high
// - Stop is data rise, ends operation
// - Data change in clock high is condition
// - Bits shift on the serial clock
// - Address top nibble must be 0100
// - Low address bits match strap pins
// - Eighth bit: one read, zero write
// - Acknowledge matching address, then do transfer
// - Receiver pulls data low on ninth clock
// - Acknowledge every written byte
// - Read sends eight bits, samples acknowledge
// - No acknowledge: release line, await stop
// - Data line is open drain only
// - Input pin undriven, output pin push-pull
// - Alert when input differs from stored bit
// - Alert clears on return or input read
// - Output-to-input switch may raise false alert
// - First write byte selects the register
// - Selected register persists until new command
// - Direction bit one is input, zero output
// - Polarity bit set inverts input data
module gx_i2c_expander
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  input  wire logic        i_addr_strap_bit0,
  input  wire logic        i_addr_strap_bit1,
  input  wire logic        i_addr_strap_bit2,
  input  wire logic [7:0]  i_port_pin,
  output logic [7:0]       o_port_out,
  output logic [7:0]       o_port_oe_n,
  output logic             o_change_alert_n,
  output logic             o_change_alert_oe_n,
  output logic             o_bus_busy
);
  import gx_pkg::*;

  // ----------------------------------------------------------------
  // System domain declarations
  // ----------------------------------------------------------------
  logic       scl_meta, scl_s, scl_d;
  logic       sda_meta, sda_s, sda_d;
  logic [7:0] pin_meta, pin_s;
  logic       wtog_meta, wtog_s, wtog_d;
  logic       rtog_meta, rtog_s, rtog_d;
  logic       start_det, stop_det;
  logic       wr_en;
  gx_regs_t   regs;
  logic [7:0] in_snap, next_in_snap;
  logic       link_rst, frame_rst;
  logic       next_frame_rst, next_busy, next_alert_n;
  logic [7:0] next_port_out, next_port_oe_n;

  // ----------------------------------------------------------------
  // Link domain declarations
  // ----------------------------------------------------------------
  gx_state_t  state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] shreg, next_shreg;
  logic       rw, next_rw;
  logic       cmd_seen, next_cmd_seen;
  logic       sda_oe_n, next_sda_oe_n;
  logic [7:0] ptr, next_ptr;
  logic       wr_tog, next_wr_tog;
  gx_wr_t     wr, next_wr;
  logic       rd_tog, next_rd_tog;
  logic [7:0] rd_snap, next_rd_snap;
  logic       bit_rise;
  logic [7:0] lpin_meta, lpin;
  logic [2:0] strap_meta, strap;
  gx_regs_t   lregs_meta, lregs;
  logic [7:0] byte_in, rd_byte;
  logic       do_load;

  // ----------------------------------------------------------------
  // System domain: input synchronisers
  // ----------------------------------------------------------------
  // Two stages before any logic, then one delay for edge detection
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      {scl_meta, scl_s, scl_d} <= 3'h7;
      {sda_meta, sda_s, sda_d} <= 3'h7;
      pin_meta                 <= RST_INPUT;
      pin_s                    <= RST_INPUT;
      {wtog_meta, wtog_s, wtog_d} <= 3'h0;
      {rtog_meta, rtog_s, rtog_d} <= 3'h0;
    end
    else if (i_ce)
    begin
      {scl_meta, scl_s, scl_d} <= {i_scl, scl_meta, scl_s};
      {sda_meta, sda_s, sda_d} <= {i_sda, sda_meta, sda_s};
      pin_meta                 <= i_port_pin;
      pin_s                    <= pin_meta;
      {wtog_meta, wtog_s, wtog_d} <= {wr_tog, wtog_meta, wtog_s};
      {rtog_meta, rtog_s, rtog_d} <= {rd_tog, rtog_meta, rtog_s};
    end
  end

  // Conditions seen from synchronised samples only
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  assign wr_en     = i_ce & (wtog_s ^ wtog_d);

  // ----------------------------------------------------------------
  // System domain: register bank
  // ----------------------------------------------------------------
  gx_regfile u_regfile
  (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_wr_en   (wr_en),
    .i_wr      (wr),
    .o_regs    (regs)
  );

  // ----------------------------------------------------------------
  // System domain: pins, alert and link resets
  // ----------------------------------------------------------------
  // Write data is held by the link until the next byte, so it is
  // stable long after the toggle has been seen here
  always_comb
  begin
    next_in_snap   = in_snap;
    if (rtog_s ^ rtog_d)
      next_in_snap = rd_snap;
    next_alert_n   = ~|(regs.cfg & (pin_s ^ in_snap));
    next_port_out  = regs.outp;
    next_port_oe_n = regs.cfg;
    next_frame_rst = stop_det;
    next_busy      = o_bus_busy;
    if (start_det)
      next_busy    = 1'b1;
    else if (stop_det)
      next_busy    = 1'b0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      in_snap             <= RST_INPUT;
      o_change_alert_n    <= 1'b1;
      o_change_alert_oe_n <= 1'b1;
      o_port_out          <= RST_OUTPUT;
      o_port_oe_n         <= RST_CONFIG;
      link_rst            <= 1'b1;
      frame_rst           <= 1'b1;
      o_bus_busy          <= 1'b0;
    end
    else if (i_ce)
    begin
      in_snap             <= next_in_snap;
      o_change_alert_n    <= next_alert_n;
      o_change_alert_oe_n <= next_alert_n;  // Open drain: enable low only while pulling low
      o_port_out          <= next_port_out;
      o_port_oe_n         <= next_port_oe_n;
      link_rst            <= 1'b0;
      frame_rst           <= next_frame_rst;
      o_bus_busy          <= next_busy;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: bit sampling and synchronisers
  // ----------------------------------------------------------------
  // Rising edge sample; a stop restores idle high, else the next start is lost
  always_ff @(posedge i_scl or posedge frame_rst)
  begin
    if (frame_rst)
      bit_rise <= 1'b1;
    else
      bit_rise <= i_sda;
  end

  // Pins, straps and registers reach the link through two stages;
  // they settle during the address byte, well before use
  always_ff @(negedge i_scl or posedge link_rst)
  begin
    if (link_rst)
    begin
      lpin_meta  <= RST_INPUT;
      lpin       <= RST_INPUT;
      strap_meta <= RST_STRAP[2:0];
      strap      <= RST_STRAP[2:0];
      lregs_meta <= RST_REGS;
      lregs      <= RST_REGS;
    end
    else
    begin
      lpin_meta  <= i_port_pin;
      lpin       <= lpin_meta;
      strap_meta <= {i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0};
      strap      <= strap_meta;
      lregs_meta <= regs;
      lregs      <= lregs_meta;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: protocol engine
  // ----------------------------------------------------------------
  assign byte_in = {shreg[6:0], bit_rise};

  // Read data of the selected register
  always_comb
  begin
    case (ptr)
      CMD_INPUT:    rd_byte = lpin ^ lregs.pol;
      CMD_OUTPUT:   rd_byte = lregs.outp;
      CMD_POLARITY: rd_byte = lregs.pol;
      CMD_CONFIG:   rd_byte = lregs.cfg;
      default:      rd_byte = 8'h00;
    endcase
  end

  // Every step happens on the falling clock edge, which keeps the
  // data line still while the clock is high
  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_shreg    = shreg;
    next_rw       = rw;
    next_cmd_seen = cmd_seen;
    next_sda_oe_n = 1'b1;  // Released unless driven below
    next_ptr      = ptr;
    next_wr_tog   = wr_tog;
    next_wr       = wr;
    next_rd_tog   = rd_tog;
    next_rd_snap  = rd_snap;
    do_load       = 1'b0;
    if (bit_rise && !i_sda)
    begin
      next_state    = ST_ADDR;
      next_cnt      = FIRST_BIT;
      next_cmd_seen = 1'b0;
    end
    else if (!bit_rise && i_sda)
      next_state = ST_IDLE;
    else
    begin
      case (state)
        ST_ADDR:
        begin
          next_shreg = byte_in;
          next_cnt   = cnt + 3'h1;
          if (cnt == LAST_BIT)
          begin
            if (byte_in[7:4] == ADDR_PREFIX && byte_in[3:1] == strap)
            begin
              next_rw       = byte_in[0];
              next_sda_oe_n = 1'b0;
              next_state    = ST_ADDR_ACK;
            end
            else
              next_state = ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          next_cnt = FIRST_BIT;
          if (rw)
            do_load    = 1'b1;
          else
            next_state = ST_WR;
        end
        ST_WR:
        begin
          next_shreg = byte_in;
          next_cnt   = cnt + 3'h1;
          if (cnt == LAST_BIT)
          begin
            next_sda_oe_n = 1'b0;
            next_state    = ST_WR_ACK;
            if (!cmd_seen)
            begin
              next_ptr      = byte_in;
              next_cmd_seen = 1'b1;
            end
            else if (ptr == CMD_OUTPUT || ptr == CMD_POLARITY || ptr == CMD_CONFIG)
            begin
              next_wr_tog = ~wr_tog;
              next_wr     = '{idx: ptr[1:0], data: byte_in};
            end
          end
        end
        ST_WR_ACK:
        begin
          next_cnt   = FIRST_BIT;
          next_state = ST_WR;
        end
        ST_RD:
        begin
          next_cnt   = cnt + 3'h1;
          next_shreg = {shreg[6:0], 1'b0};
          if (cnt == LAST_BIT)
            next_state    = ST_RD_ACK;
          else
            next_sda_oe_n = shreg[6];
        end
        ST_RD_ACK:
        begin
          next_cnt = FIRST_BIT;
          if (!bit_rise)
            do_load    = 1'b1;
          else
            next_state = ST_WAIT_STOP;
        end
        ST_IDLE, ST_WAIT_STOP:
          next_state = state;
        default:
          next_state = ST_IDLE;
      endcase
    end
    // Load a read byte and put its first bit on the line at once
    if (do_load)
    begin
      next_state    = ST_RD;
      next_shreg    = rd_byte;
      next_sda_oe_n = rd_byte[7];
      if (ptr == CMD_INPUT)
      begin
        next_rd_tog  = ~rd_tog;
        next_rd_snap = lpin;
      end
    end
  end

  // Frame state: cleared by a stop, caught in the system domain
  // because the serial clock has no falling edge after it
  always_ff @(negedge i_scl or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      state    <= ST_IDLE;
      cnt      <= FIRST_BIT;
      shreg    <= 8'h00;
      rw       <= 1'b0;
      cmd_seen <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      shreg    <= next_shreg;
      rw       <= next_rw;
      cmd_seen <= next_cmd_seen;
      sda_oe_n <= next_sda_oe_n;
    end
  end

  // Pointer and handshake words outlive the frame
  always_ff @(negedge i_scl or posedge link_rst)
  begin
    if (link_rst)
    begin
      ptr     <= RST_PTR;
      wr_tog  <= 1'b0;
      wr      <= RST_WR;
      rd_tog  <= 1'b0;
      rd_snap <= RST_INPUT;
    end
    else
    begin
      ptr     <= next_ptr;
      wr_tog  <= next_wr_tog;
      wr      <= next_wr;
      rd_tog  <= next_rd_tog;
      rd_snap <= next_rd_snap;
    end
  end

  // ----------------------------------------------------------------
  // Serial data pin, pulled low only
  // ----------------------------------------------------------------
  assign o_sda_oe_n = sda_oe_n;
  assign o_sda      = 1'b0;      // Never drives high

endmodule

`default_nettype wire

// >>> gx_chk_assertions.sv
/*
  Port checker for the expander slave front end.
  Assumes it is bound to gx_i2c_expander and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module gx_chk
(
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_ce,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe_n,
  input wire logic       i_addr_strap_bit0,
  input wire logic       i_addr_strap_bit1,
  input wire logic       i_addr_strap_bit2,
  input wire logic [7:0] i_port_pin,
  input wire logic [7:0] o_port_out,
  input wire logic [7:0] o_port_oe_n,
  input wire logic       o_change_alert_n,
  input wire logic       o_change_alert_oe_n,
  input wire logic       o_bus_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------
  // Line conditions and pin drivers
  // ----------------------------------------------------------------
  // Open drain: only the enable may move
  sda_never_high_a: assert property (o_sda == 1'b0) else $error("data value not low");
  alert_open_drain_a: assert property (o_change_alert_oe_n == o_change_alert_n)
    else $error("alert enable differs from alert");
  start_sets_busy_a: assert property ($fell(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] o_bus_busy)
    else $error("start not seen");
  stop_ends_busy_a: assert property ($rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] !o_bus_busy)
    else $error("stop not seen");
  // The data line is not pulled low outside a frame
  idle_release_a: assert property (!o_bus_busy |-> o_sda_oe_n) else $error("data pulled while idle");
  // Driven level may only move while the clock is low
  drive_low_phase_a: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("data moved in clock high");
  dir_by_bus_a: assert property ($changed(o_port_oe_n) |-> o_bus_busy)
    else $error("direction moved outside a frame");
  out_by_bus_a: assert property ($changed(o_port_out) |-> o_bus_busy)
    else $error("output moved outside a frame");
endmodule

bind gx_i2c_expander gx_chk u_chk
(
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_addr_strap_bit0(i_addr_strap_bit0),
  .i_addr_strap_bit1(i_addr_strap_bit1), .i_addr_strap_bit2(i_addr_strap_bit2),
  .i_port_pin(i_port_pin), .o_port_out(o_port_out), .o_port_oe_n(o_port_oe_n),
  .o_change_alert_n(o_change_alert_n), .o_change_alert_oe_n(o_change_alert_oe_n), .o_bus_busy(o_bus_busy)
);

`default_nettype wire

// >>> gx_master.sv
/*
  Behavioural bus master that makes the serial clock and conditions.
  Assumes a pull-up on the data line; the clock stands high between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module gx_master
(
  output logic      o_scl,
  output logic      o_sda_pull,
  input  wire logic i_sda
);
  // Idle bus: clock high, data released
  initial
  begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // One clock of 160 ns; data moves mid low phase, sampled late in high
  task automatic bit_io(input logic b, output logic s);
    o_sda_pull = !b;
    #40 o_scl = 1'b1;
    #70 s = i_sda;
    #10 o_scl = 1'b0;
    #40;
  endtask

  // Works from idle and as a repeated start; clock held high over
  // three system cycles each side so the condition detector sees it
  task automatic start();
    o_sda_pull = 1'b0;
    #40 o_scl = 1'b1;
    #160 o_sda_pull = 1'b1;
    #160 o_scl = 1'b0;
    #40;
  endtask

  // Long free time so the stop detector and frame reset settle
  task automatic stop();
    o_sda_pull = 1'b1;
    #40 o_scl = 1'b1;
    #160 o_sda_pull = 1'b0;
    #400;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // Acknowledge only when told to; a refusal is followed by stop
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, s);
  endtask
endmodule

`default_nettype wire

// >>> tb.sv
/*
  Self-checking bench for the expander slave with a register model.
  Assumes gx_pkg, the design, gx_master and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import gx_pkg::*;
  logic clk = 1'b0, rst = 1'b1, scl, pull;
  logic [2:0] strap = 3'h0;
  logic [7:0] pin_drv = 8'hff, o_out, o_oe_n, m_out = RST_OUTPUT, m_pol = RST_POLARITY, m_cfg = RST_CONFIG, ptr;
  logic sda_oe_n, sda_v, al_n, al_oe_n, busy;
  int seed = 15, err_total = 0, check_count = 0;
  int cmds[6] = '{0, 4, 5, 1, 2, 3};
  // Pull-ups on data and alert; output pins follow their flops
  wire sda = !pull && (sda_oe_n || sda_v);
  wire alert = al_oe_n || al_n;
  wire [7:0] pins = (pin_drv & o_oe_n) | (o_out & ~o_oe_n);

  always #25 clk = ~clk;

  gx_master m (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));
  gx_i2c_expander uut
  (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_scl(scl), .i_sda(sda), .o_sda(sda_v),
    .o_sda_oe_n(sda_oe_n), .i_addr_strap_bit0(strap[0]), .i_addr_strap_bit1(strap[1]),
    .i_addr_strap_bit2(strap[2]), .i_port_pin(pins), .o_port_out(o_out), .o_port_oe_n(o_oe_n),
    .o_change_alert_n(al_n), .o_change_alert_oe_n(al_oe_n), .o_bus_busy(busy)
  );

  // Model register view; unknown pointers read zero
  function automatic logic [7:0] m_reg(input logic [7:0] c);
    case (c)
      CMD_INPUT:    return ((pin_drv & m_cfg) | (m_out & ~m_cfg)) ^ m_pol;
      CMD_OUTPUT:   return m_out;
      CMD_POLARITY: return m_pol;
      CMD_CONFIG:   return m_cfg;
      default:      return 8'h00;
    endcase
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Frame with a foreign address must not be answered
  task automatic foreign(input logic [7:0] ad);
    logic a;
    m.start();
    m.wbyte(ad, a);
    chk("foreign ack", 8'h00, {7'h00, a});
    m.stop();
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic a0, a1, a2;
    m.start();
    m.wbyte({ADDR_PREFIX, strap, 1'b0}, a0);
    m.wbyte(c, a1);
    m.wbyte(d, a2);
    m.stop();
    chk("write acks", 8'h07, {5'h00, a0, a1, a2});
    ptr = c;
    if (c == CMD_OUTPUT) m_out = d;
    if (c == CMD_POLARITY) m_pol = d;
    if (c == CMD_CONFIG) m_cfg = d;
    repeat (4) @(negedge clk);
    chk("port out", m_out, o_out);
    chk("port dir", m_cfg, o_oe_n);
    chk("idle", 8'h00, {7'h00, busy});
  endtask

  // Optional pointer set, repeated start, two bytes: ack then refuse
  task automatic rd(input logic [7:0] c, input logic use_cmd);
    logic a;
    logic [7:0] b;
    m.start();
    if (use_cmd)
    begin
      m.wbyte({ADDR_PREFIX, strap, 1'b0}, a);
      m.wbyte(c, a);
      ptr = c;
      m.start();
    end
    m.wbyte({ADDR_PREFIX, strap, 1'b1}, a);
    chk("read ack", 8'h01, {7'h00, a});
    chk("busy", 8'h01, {7'h00, busy});
    m.rbyte(b, 1'b1);
    chk("read byte", m_reg(ptr), b);
    m.rbyte(b, 1'b0);
    chk("read again", m_reg(ptr), b);
    chk("released", 8'h01, {7'h00, sda_oe_n});
    m.stop();
  endtask

  task automatic flip_pin(input logic e);
    pin_drv[3] = ~pin_drv[3];
    repeat (8) @(negedge clk);
    chk("alert", {7'h00, e}, {7'h00, alert});
  endtask

  // Watchdog well beyond the expected 130 us
  initial
  begin
    #2000000;
    err_total++;
    summarize();
  end

  initial
  begin
    strap = 3'($random(seed));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk("reset dir", RST_CONFIG, o_oe_n);
    chk("reset out", RST_OUTPUT, o_out);
    chk("reset alert", 8'h01, {7'h00, alert});
    foreign({4'h5, strap, 1'b0});
    foreign({ADDR_PREFIX, strap ^ 3'h1, 1'b0});
    pin_drv = 8'($random(seed));
    // Every command, ignored and unknown ones included
    foreach (cmds[k])
    begin
      wr(8'(cmds[k]), 8'($random(seed)));
      rd(cmds[k], 1'b1);
    end
    rd(8'h00, 1'b0);
    rd(CMD_INPUT, 1'b1);
    // Alert raised by an input, cleared by return and by a read
    wr(CMD_CONFIG, 8'hff);
    rd(CMD_INPUT, 1'b1);
    @(negedge clk);
    flip_pin(1'b0);
    flip_pin(1'b1);
    flip_pin(1'b0);
    rd(CMD_INPUT, 1'b1);
    repeat (8) @(negedge clk);
    chk("alert read", 8'h01, {7'h00, alert});
    summarize();
  end
endmodule

`default_nettype wire
